// file: design/lcc_pkg.sv
package lcc_pkg;

  localparam int LANES = 8;

  // Lane result codes
  localparam logic [3:0] NO_INFO_CODE = 4'h0;
  localparam logic [3:0] CMD_OK_CODE = 4'h1;
  localparam logic [3:0] GENERIC_REJECT_CODE = 4'h2;
  localparam logic [3:0] BAD_APPLICATION_REJECT_CODE = 4'h3;
  localparam logic [3:0] BAD_LANE_SET_REJECT_CODE = 4'h4;
  localparam logic [3:0] BAD_SIGNAL_INTEGRITY_REJECT_CODE = 4'h5;
  localparam logic [3:0] LANES_BUSY_REJECT_CODE = 4'h6;
  localparam logic [3:0] PARTIAL_PATH_REJECT_CODE = 4'h7;
  localparam logic [3:0] RESERVED_FIRST_CODE = 4'h8;
  localparam logic [3:0] RESERVED_LAST_CODE = 4'hb;
  localparam logic [3:0] CMD_BUSY_CODE = 4'hc;
  localparam logic [3:0] CUSTOM_REJECT_CODE = 4'hd;

  // Register indices, byte address is four times the index
  localparam logic [7:0] LANE_ONE_TWO_CFG_RESULT_IDX = 8'hca;
  localparam logic [7:0] LANE_THREE_FOUR_CFG_RESULT_IDX = 8'hcb;
  localparam logic [7:0] LANE_FIVE_SIX_CFG_RESULT_IDX = 8'hcc;
  localparam logic [7:0] LANE_SEVEN_EIGHT_CFG_RESULT_IDX = 8'hcd;
  localparam logic [7:0] SET0_PATH_INIT_IDX = 8'h10;
  localparam logic [7:0] SET0_INSTANT_IDX = 8'h11;
  localparam logic [7:0] SET1_PATH_INIT_IDX = 8'h12;
  localparam logic [7:0] SET1_INSTANT_IDX = 8'h13;
  localparam logic [7:0] SET0_CFG_IDX = 8'h14;
  localparam logic [7:0] SET1_CFG_IDX = 8'h15;
  localparam logic [7:0] ENGINE_STATUS_IDX = 8'h16;
  localparam logic [7:0] ACTIVE_LANE1_IDX = 8'h20;

  // Staged config field positions
  localparam int CFG_APP_LSB = 0;
  localparam int CFG_SI_LSB = 4;
  localparam int CFG_FIRST_LSB = 8;
  localparam int CFG_CUSTOM_BIT = 11;
  localparam logic [11:0] CFG_RESET = 12'h000;

  // Active control set defaults and limits
  localparam logic [3:0] DEFAULT_APP = 4'h1;
  localparam logic [3:0] DEFAULT_SI = 4'h0;
  localparam logic [3:0] SI_MAX = 4'h7;

  // Procedure run time
  localparam int CLK_PERIOD_NS = 50;
  localparam int EXEC_TIME_NS = 400;
  localparam logic [3:0] EXEC_CYCLES =
    4'((EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// file: design/lcc_top.sv
// Function
// - Apply write runs acceptance, validation, execution, feedback in order.
// - Accepted trigger marks every triggered lane busy at once.
// - Trigger on a busy lane is dropped silently, fields untouched.
// - Invalid staged settings skip execution and report a rejection.
// - Feedback overwrites each triggered lane field with the final result.
// - A result code in a field means ready for a new command.
// - All triggered lanes of one path get the same value.
// - Triggers cover whole paths; live instant triggers may be partial.
// - Any applicable result code may be reported, no precedence.
// - Eight read-only nibbles in four bytes, odd lane low nibble.
// - Code 0 means no information and is the initial value.
// - Code 1 reports the last accepted command succeeded.
// - Codes 2 to 7 report the defined rejection causes.
// - Codes 8 to B reserved; D to F for custom rejections.
// - Code C means busy; new triggers for that lane ignored.
// - Busy shown by lane fields; apply spare bits are private debug.
// - Active set loaded with defaults before leaving boot state.
// - Each field holds state and result of latest accepted command.
`timescale 1ns/10ps
module lcc_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [9:0] address,
  input wire logic [3:0] byteenable,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [7:0] lane_path_off,
  input wire logic [7:0] lane_path_live,
  output logic boot_done,
  output logic [31:0] active_app_sel,
  output logic [31:0] active_si
);

  typedef enum {ENG_IDLE, ENG_CHECK, ENG_RUN, ENG_DONE} lcc_eng_t;

  lcc_eng_t eng_st;
  logic [31:0] cmd_result_register;
  logic [7:0] cmd_mask;
  logic [11:0] cmd_cfg;
  logic cmd_init;
  logic [3:0] result;
  logic [3:0] run_cnt;
  logic [11:0] cfg0;
  logic [11:0] cfg1;
  logic [7:0] drop_cnt;
  logic [7:0] last_mask;
  logic [31:0] rd_mux;
  logic [3:0] check_code;
  logic is_apply;
  logic apply_set1;
  logic apply_init;
  logic done_write;
  logic accept;
  logic drop;
  logic can_go;

  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    return a == {idx, 2'b00};
  endfunction

  function automatic logic any_busy(input logic [31:0] st,
                                    input logic [7:0] m);
    logic r;
    r = 1'b0;
    for (int i = 0; i < lcc_pkg::LANES; i++) begin
      if (m[i] && st[i*4+:4] == lcc_pkg::CMD_BUSY_CODE) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic all_code(input logic [31:0] st,
                                    input logic [7:0] m,
                                    input logic [3:0] code);
    logic r;
    r = 1'b1;
    for (int i = 0; i < lcc_pkg::LANES; i++) begin
      if (m[i] && st[i*4+:4] != code) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  // Lanes per path for each application
  function automatic logic [3:0] app_width(input logic [3:0] app);
    logic [3:0] w;
    case (app)
      4'h1: w = 4'h1;
      4'h2: w = 4'h2;
      4'h3: w = 4'h4;
      4'h4: w = 4'h8;
      default: w = 4'h0;
    endcase
    return w;
  endfunction

  function automatic logic [3:0] check_cfg(input logic [7:0] m,
                                           input logic [11:0] cfg,
                                           input logic init_kind,
                                           input logic [7:0] off,
                                           input logic [7:0] live);
    logic [3:0] w;
    logic [2:0] first;
    logic [15:0] span;
    logic [7:0] pm;
    logic [3:0] res;
    w = app_width(cfg[lcc_pkg::CFG_APP_LSB+:4]);
    first = cfg[lcc_pkg::CFG_FIRST_LSB+:3];
    span = ((16'h0001 << w) - 16'h0001) << first;
    pm = span[7:0];
    res = lcc_pkg::CMD_OK_CODE;
    // First failing check wins; any order is acceptable
    if (m == 8'h00) begin
      res = lcc_pkg::GENERIC_REJECT_CODE;
    end else if (w == 4'h0) begin
      res = lcc_pkg::BAD_APPLICATION_REJECT_CODE;
    end else if (span[15:8] != 8'h00 ||
                 ({1'b0, first} & (w - 4'h1)) != 4'h0 ||
                 (m & ~pm) != 8'h00) begin
      res = lcc_pkg::BAD_LANE_SET_REJECT_CODE;
    end else if (cfg[lcc_pkg::CFG_SI_LSB+:4] > lcc_pkg::SI_MAX) begin
      res = lcc_pkg::BAD_SIGNAL_INTEGRITY_REJECT_CODE;
    end else if (init_kind && (m & ~off) != 8'h00) begin
      res = lcc_pkg::LANES_BUSY_REJECT_CODE;
    end else if (m != pm &&
                 (init_kind || (m & ~live) != 8'h00)) begin
      // Partial lanes only for instant triggers on live lanes
      res = lcc_pkg::PARTIAL_PATH_REJECT_CODE;
    end else if (cfg[lcc_pkg::CFG_CUSTOM_BIT]) begin
      res = lcc_pkg::CUSTOM_REJECT_CODE;
    end
    return res;
  endfunction

  // Apply register decode
  always_comb begin
    is_apply = (hit(address, lcc_pkg::SET0_PATH_INIT_IDX) ||
                hit(address, lcc_pkg::SET0_INSTANT_IDX) ||
                hit(address, lcc_pkg::SET1_PATH_INIT_IDX) ||
                hit(address, lcc_pkg::SET1_INSTANT_IDX)) &&
               byteenable[0];
    apply_set1 = hit(address, lcc_pkg::SET1_PATH_INIT_IDX) ||
                 hit(address, lcc_pkg::SET1_INSTANT_IDX);
    apply_init = hit(address, lcc_pkg::SET0_PATH_INIT_IDX) ||
                 hit(address, lcc_pkg::SET1_PATH_INIT_IDX);
  end

  // Acceptance decision at the completing edge
  always_comb begin
    done_write = write && !waitrequest && is_apply;
    drop = done_write && any_busy(cmd_result_register, writedata[7:0]);
    accept = done_write && !drop && eng_st == ENG_IDLE;
  end

  // Busy-engine stall for triggers on lanes that are not busy
  always_comb begin
    can_go = !(write && is_apply && eng_st != ENG_IDLE &&
               !any_busy(cmd_result_register, writedata[7:0]));
  end

  always_comb begin
    check_code = check_cfg(cmd_mask, cmd_cfg, cmd_init,
                           lane_path_off, lane_path_live);
  end

  // Read mux, odd lane in low nibble
  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int k = 0; k < 4; k++) begin
      if (hit(address, lcc_pkg::LANE_ONE_TWO_CFG_RESULT_IDX + 8'(k))) begin
        rd_mux = {24'h00_0000, cmd_result_register[k*8+:8]};
      end
    end
    for (int i = 0; i < lcc_pkg::LANES; i++) begin
      if (hit(address, lcc_pkg::ACTIVE_LANE1_IDX + 8'(i))) begin
        rd_mux = {24'h00_0000, active_si[i*4+:4], active_app_sel[i*4+:4]};
      end
    end
    if (is_apply) begin
      // Spare apply bits carry private debug only
      rd_mux = {15'h0000, eng_st != ENG_IDLE, last_mask, 8'h00};
    end
    if (hit(address, lcc_pkg::SET0_CFG_IDX)) begin
      rd_mux = {20'h0_0000, cfg0};
    end
    if (hit(address, lcc_pkg::SET1_CFG_IDX)) begin
      rd_mux = {20'h0_0000, cfg1};
    end
    if (hit(address, lcc_pkg::ENGINE_STATUS_IDX)) begin
      rd_mux = {16'h0000, drop_cnt, 4'h0, result};
    end
  end

  // Avalon slave handshake, one wait cycle minimum
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else if (!waitrequest) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && boot_done && can_go) begin
      waitrequest <= 1'b0;
      readdata <= read ? rd_mux : 32'h0000_0000;
    end
  end

  // Staged control sets
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg0 <= lcc_pkg::CFG_RESET;
      cfg1 <= lcc_pkg::CFG_RESET;
    end else if (write && !waitrequest) begin
      if (hit(address, lcc_pkg::SET0_CFG_IDX)) begin
        if (byteenable[0]) begin
          cfg0[7:0] <= writedata[7:0];
        end
        if (byteenable[1]) begin
          cfg0[11:8] <= writedata[11:8];
        end
      end
      if (hit(address, lcc_pkg::SET1_CFG_IDX)) begin
        if (byteenable[0]) begin
          cfg1[7:0] <= writedata[7:0];
        end
        if (byteenable[1]) begin
          cfg1[11:8] <= writedata[11:8];
        end
      end
    end
  end

  // Debug drop counter and last accepted mask
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drop_cnt <= 8'h00;
      last_mask <= 8'h00;
    end else begin
      if (drop && drop_cnt != 8'hff) begin
        drop_cnt <= drop_cnt + 8'h01;
      end
      if (accept) begin
        last_mask <= writedata[7:0];
      end
    end
  end

  // Boot state lasts one cycle after reset release
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      boot_done <= 1'b0;
    end else begin
      boot_done <= 1'b1;
    end
  end

  // Command engine
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eng_st <= ENG_IDLE;
      cmd_mask <= 8'h00;
      cmd_cfg <= lcc_pkg::CFG_RESET;
      cmd_init <= 1'b0;
      result <= lcc_pkg::NO_INFO_CODE;
      run_cnt <= 4'h0;
    end else begin
      case (eng_st)
        ENG_IDLE: begin
          if (accept) begin
            eng_st <= ENG_CHECK;
            cmd_mask <= writedata[7:0];
            cmd_cfg <= apply_set1 ? cfg1 : cfg0;
            cmd_init <= apply_init;
          end
        end
        ENG_CHECK: begin
          result <= check_code;
          run_cnt <= 4'h0;
          if (check_code == lcc_pkg::CMD_OK_CODE) begin
            eng_st <= ENG_RUN;
          end else begin
            eng_st <= ENG_DONE;
          end
        end
        ENG_RUN: begin
          if (run_cnt == lcc_pkg::EXEC_CYCLES - 4'h1) begin
            eng_st <= ENG_DONE;
          end else begin
            run_cnt <= run_cnt + 4'h1;
          end
        end
        ENG_DONE: begin
          eng_st <= ENG_IDLE;
        end
        default: begin
          eng_st <= ENG_IDLE;
        end
      endcase
    end
  end

  generate
    for (genvar gi = 0; gi < lcc_pkg::LANES; gi++) begin : g_lane
      // Lane result field
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          cmd_result_register[gi*4+:4] <= lcc_pkg::NO_INFO_CODE;
        end else if (accept && writedata[gi]) begin
          cmd_result_register[gi*4+:4] <= lcc_pkg::CMD_BUSY_CODE;
        end else if (eng_st == ENG_DONE && cmd_mask[gi]) begin
          cmd_result_register[gi*4+:4] <= result;
        end
      end

      // Active control set lane
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          active_app_sel[gi*4+:4] <= 4'h0;
          active_si[gi*4+:4] <= 4'h0;
        end else if (!boot_done) begin
          active_app_sel[gi*4+:4] <= lcc_pkg::DEFAULT_APP;
          active_si[gi*4+:4] <= lcc_pkg::DEFAULT_SI;
        end else if (eng_st == ENG_DONE && cmd_mask[gi] &&
                     result == lcc_pkg::CMD_OK_CODE) begin
          active_app_sel[gi*4+:4] <= cmd_cfg[lcc_pkg::CFG_APP_LSB+:4];
          active_si[gi*4+:4] <= cmd_cfg[lcc_pkg::CFG_SI_LSB+:4];
        end
      end
    end
  endgenerate

  default clocking lcc_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  busy_mark_a: assert property (
    accept |=> all_code(cmd_result_register, cmd_mask,
                        lcc_pkg::CMD_BUSY_CODE))
    else $error("Accepted lanes not marked busy");

  drop_quiet_a: assert property (
    drop && eng_st != ENG_DONE |=> $stable(cmd_result_register)
                                   && eng_st != ENG_IDLE)
    else $error("Dropped trigger changed lane fields");

  step_order_a: assert property (
    accept |=> eng_st == ENG_CHECK ##1
               (eng_st == ENG_RUN || eng_st == ENG_DONE))
    else $error("Command steps out of order");

  reject_skip_a: assert property (
    eng_st == ENG_CHECK && check_code != lcc_pkg::CMD_OK_CODE
    |=> eng_st == ENG_DONE && result == $past(check_code))
    else $error("Invalid settings not rejected directly");

  run_length_a: assert property (
    $rose(eng_st == ENG_RUN) |-> (eng_st == ENG_RUN)[*8]
                                 ##1 eng_st == ENG_DONE)
    else $error("Execution time wrong");

  ok_code_a: assert property (
    eng_st == ENG_DONE && $past(eng_st) == ENG_RUN
    |-> result == lcc_pkg::CMD_OK_CODE)
    else $error("Completed run not reported as success");

  feedback_a: assert property (
    eng_st == ENG_DONE |=>
      all_code(cmd_result_register, cmd_mask, $past(result)) &&
      !any_busy(cmd_result_register, cmd_mask))
    else $error("Result not written to all lanes");

  init_zero_a: assert property (
    !boot_done |-> cmd_result_register == 32'h0000_0000)
    else $error("Lane fields not initially zero");

  boot_load_a: assert property (
    $rose(boot_done) |-> active_app_sel == {8{lcc_pkg::DEFAULT_APP}}
                         && active_si == {8{lcc_pkg::DEFAULT_SI}})
    else $error("Active set defaults missing after boot");

  result_range_a: assert property (
    eng_st == ENG_DONE |-> result != lcc_pkg::CMD_BUSY_CODE &&
      result != lcc_pkg::NO_INFO_CODE &&
      (result < lcc_pkg::RESERVED_FIRST_CODE ||
       result > lcc_pkg::RESERVED_LAST_CODE))
    else $error("Result code out of allowed set");

  busy_hold_a: assert property (
    drop |-> eng_st != ENG_IDLE)
    else $error("Busy lane seen while engine idle");

endmodule

// file: dv/lcc_path_model.sv
`timescale 1ns/10ps
module lcc_path_model (
  input wire logic live_mode,
  output logic [7:0] lane_path_off,
  output logic [7:0] lane_path_live
);
  // Every lane is either deactivated or running, never both
  assign lane_path_off = live_mode ? 8'h00 : 8'hff;
  assign lane_path_live = live_mode ? 8'hff : 8'h00;
endmodule

// file: dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic core_clk;
  logic rst;
  logic [9:0] address;
  logic [3:0] byteenable;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic live_mode;
  logic [7:0] lane_path_off;
  logic [7:0] lane_path_live;
  logic boot_done;
  logic [31:0] active_app_sel;
  logic [31:0] active_si;
  logic [31:0] exp_q[$];
  logic [3:0] exp_lane [8];
  logic [3:0] si;
  int fails;
  int checks;
  // Code, mask, staged cfg, instant kind, lanes live
  localparam logic [31:0] rows [8] = '{32'h0000_5013, 32'h0010_2064,
    32'h0008_1015, 32'h0200_1016, 32'h0000_2017, 32'h0080_101d,
    32'h0300_2011, 32'h0100_2017};

  lcc_top i_lcc_top (
    .core_clk(core_clk),
    .rst(rst),
    .address(address),
    .byteenable(byteenable),
    .read(read),
    .write(write),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .lane_path_off(lane_path_off),
    .lane_path_live(lane_path_live),
    .boot_done(boot_done),
    .active_app_sel(active_app_sel),
    .active_si(active_si)
  );

  lcc_path_model i_lcc_path_model (
    .live_mode(live_mode),
    .lane_path_off(lane_path_off),
    .lane_path_live(lane_path_live)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Request held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [9:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    write <= we;
    read <= ~we;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  function automatic logic [31:0] lanes(input int k);
    return {24'h00_0000, exp_lane[2 * k + 1], exp_lane[2 * k]};
  endfunction

  task automatic rd_lanes();
    for (int k = 0; k < 4; k++) begin
      rd(10'(10'h328 + 4 * k), lanes(k));
    end
  endtask

  task automatic trig(input int set, input int kind, input logic [11:0] cfg,
                      input logic [7:0] mask, input logic [3:0] code);
    bus(1'b1, 10'(10'h050 + 4 * set), {20'h0_0000, cfg});
    bus(1'b1, 10'(10'h040 + 8 * set + 4 * kind), {24'h0, mask});
    for (int i = 0; i < 8; i++) begin
      if (mask[i]) begin
        exp_lane[i] = code;
      end
    end
    repeat (12) @(posedge core_clk);
    rd_lanes();
  endtask

  always @(posedge core_clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      check(readdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    address = 10'h000;
    byteenable = 4'hf;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    live_mode = 1'b0;
    fails = 0;
    checks = 0;
    foreach (exp_lane[i]) exp_lane[i] = 4'h0;
    void'($urandom(32'hbb06));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd_lanes();
    check({31'h0, boot_done}, 32'h0000_0001);
    check(active_app_sel, 32'h1111_1111);
    check(active_si, 32'h0000_0000);
    // Two-lane path on lanes 1 and 2 with a random legal SI
    si = 4'($urandom_range(7));
    bus(1'b1, 10'h050, {20'h0_0000, 4'h0, si, 4'h2});
    bus(1'b1, 10'h040, 32'h0000_0003);
    rd(10'h328, 32'h0000_00cc);
    bus(1'b1, 10'h048, 32'h0000_0003);
    repeat (12) @(posedge core_clk);
    exp_lane[0] = 4'h1;
    exp_lane[1] = 4'h1;
    rd_lanes();
    check(active_app_sel, 32'h1111_1122);
    check(active_si, {24'h00_0000, si, si});
    rd(10'h058, 32'h0000_0101);
    for (int r = 0; r < 8; r++) begin
      live_mode <= rows[r][25];
      trig(r % 2, int'(rows[r][24]), rows[r][23:12], rows[r][11:4],
           rows[r][3:0]);
    end
    // Empty lane mask is rejected without touching any lane
    bus(1'b1, 10'h040, 32'h0000_0000);
    repeat (12) @(posedge core_clk);
    rd(10'h058, 32'h0000_0102);
    rd_lanes();
    bus(1'b1, 10'h328, 32'hffff_ffff);
    rd(10'h328, lanes(0));
    rd(10'h3fc, 32'h0000_0000);
    // Reset at the edge that accepts the trigger brings every field back to no information
    bus(1'b1, 10'h040, 32'h0000_0003);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    foreach (exp_lane[i]) exp_lane[i] = 4'h0;
    rd_lanes();
    check(active_app_sel, 32'h1111_1111);
    summarize();
  end
endmodule
